/* verilog/exec_cfg.svh */
// Behaviour
// RULE1 - I/O bit set, two cycles, flags kept
// RULE2 - I/O bit clear, two cycles, flags kept
// RULE3 - Logical left shift, zero in, one cycle
// RULE4 - Logical right shift, zero in, one cycle
// RULE5 - Rotate left through carry, one cycle
// RULE6 - Rotate right through carry, one cycle
// RULE7 - Arithmetic right shift keeps bit seven
// RULE8 - Nibble swap, one cycle, flags kept
// RULE9 - Set or clear one C/N/Z/V flag
// RULE10 - Set or clear H/S/T/I flag
// RULE11 - Copy register bit into T flag
// RULE12 - Copy T flag into register bit
// RULE13 - Indirect load, two cycles, optional post-increment
// RULE14 - Pre-decrement pointer, then load, two cycles
// RULE15 - Displaced load, pointer unchanged, two cycles
// RULE16 - Copy, pair copy, immediate: one cycle
// RULE17 - Shift flags: Z, N=bit7, V=N^C
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

////////////////////////////////////////////////////////////////////////
`define OFF_CMD      8'h00
`define OFF_FLAGS    8'h04
`define OFF_SEL      8'h08
`define OFF_DATA     8'h0C
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`define FLAGS_RST    8'h00
`define CMD_RST      32'h0000_0000
`define CMD_OP_F     4:0
`define CMD_DST_F    12:8
`define CMD_SRC_F    20:16
`define CMD_IMM_F    31:24

////////////////////////////////////////////////////////////////////////
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_T 3'h6

////////////////////////////////////////////////////////////////////////
`define OP_IO_SET     5'h00
`define OP_IO_CLR     5'h01
`define OP_SHIFT_L    5'h02
`define OP_SHIFT_R    5'h03
`define OP_ROT_L      5'h04
`define OP_ROT_R      5'h05
`define OP_SHIFT_A    5'h06
`define OP_SWAP       5'h07
`define OP_FLAG_SET   5'h08
`define OP_FLAG_CLR   5'h09
`define OP_T_STORE    5'h0A
`define OP_T_LOAD     5'h0B
`define OP_COPY       5'h0C
`define OP_COPY_PAIR  5'h0D
`define OP_IMM        5'h0E
`define OP_LOAD       5'h0F
`define OP_LOAD_DISP  5'h10
`define MODE_POST     2'h1
`define MODE_PRE      2'h2
`define PTR_BASE      5'h1A

`endif

/* verilog/exec_pkg.sv */
package exec_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_MEM} phase_e;

  typedef struct packed {
    logic        re;
    logic        we;
    logic        io;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;

  typedef struct packed {
    logic [31:0][7:0] rf;
    logic [7:0]       flags;
    logic [31:0]      cmd;
    logic             go;
    logic             busy;
    phase_e           ph;
    logic             awready;
    logic             wready;
    logic             arready;
    logic             aw_got;
    logic [7:0]       aw_addr;
    logic             w_got;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [4:0]       sel;
    mem_req_s         mem;
  } state_s;
endpackage

/* verilog/bit_flag_load_exec_unit.sv */
`timescale 1ns/1ps
`include "exec_cfg.svh"
module bit_flag_load_exec_unit
  import exec_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output mem_req_s         mem_req,
  input  wire logic [7:0]  mem_rdata,
  output logic             busy
);

  state_s      st_reg;
  state_s      st_next;
  logic [4:0]  op;
  logic [4:0]  d_idx;
  logic [4:0]  r_idx;
  logic [7:0]  imm;
  logic [2:0]  bit_idx;
  logic [4:0]  p_idx;
  logic [15:0] ptr;
  logic [7:0]  rd_val;
  logic        is_busy;

  assign op      = st_reg.cmd[`CMD_OP_F];
  assign d_idx   = st_reg.cmd[`CMD_DST_F];
  assign r_idx   = st_reg.cmd[`CMD_SRC_F];
  assign imm     = st_reg.cmd[`CMD_IMM_F];
  assign bit_idx = imm[2:0];
  assign p_idx   = `PTR_BASE + {2'h0, r_idx[3:2], 1'b0};
  assign ptr     = {st_reg.rf[p_idx + 5'h01], st_reg.rf[p_idx]};
  assign rd_val  = st_reg.rf[d_idx];
  assign is_busy = st_reg.go || (st_reg.ph == PH_MEM);

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0]  res;
    logic        cy;
    logic        sh;
    logic [15:0] pn;
    logic [4:0]  dp;
    logic [4:0]  rp;
    res = 8'h00;
    cy  = 1'b0;
    sh  = 1'b0;
    pn  = 16'h0000;
    dp  = {d_idx[4:1], 1'b0};
    rp  = {r_idx[4:1], 1'b0};
    st_next = st_reg;
    st_next.go     = 1'b0;
    st_next.mem.re = 1'b0;
    st_next.mem.we = 1'b0;

    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    if (awvalid && st_reg.awready) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = awaddr;
    end
    if (wvalid && st_reg.wready) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = wdata;
      st_next.w_strb = wstrb;
    end

    // Address and data may arrive in either order
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = `RESP_OKAY;
      if (st_reg.aw_addr == `OFF_SEL) begin
        if (st_reg.w_strb[0]) begin
          st_next.sel = st_reg.w_data[4:0];
        end
      end else if (is_busy) begin
        // Refused so software never races the executing command
        st_next.bresp = `RESP_SLVERR;
      end else if (st_reg.aw_addr == `OFF_CMD) begin
        for (int i = 0; i < 4; i++) begin
          if (st_reg.w_strb[i]) begin
            st_next.cmd[i*8 +: 8] = st_reg.w_data[i*8 +: 8];
          end
        end
        st_next.go = 1'b1;
      end else if (st_reg.aw_addr == `OFF_FLAGS) begin
        if (st_reg.w_strb[0]) begin
          st_next.flags = st_reg.w_data[7:0];
        end
      end else if (st_reg.aw_addr == `OFF_DATA) begin
        if (st_reg.w_strb[0]) begin
          st_next.rf[st_reg.sel] = st_reg.w_data[7:0];
        end
      end else begin
        st_next.bresp = `RESP_SLVERR;
      end
    end

    if (arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      if (araddr == `OFF_CMD) begin
        st_next.rdata = st_reg.cmd;
      end else if (araddr == `OFF_FLAGS) begin
        st_next.rdata = {23'h000000, is_busy, st_reg.flags};
      end else if (araddr == `OFF_SEL) begin
        st_next.rdata = {27'h0000000, st_reg.sel};
      end else if (araddr == `OFF_DATA) begin
        st_next.rdata = {24'h000000, st_reg.rf[st_reg.sel]};
      end else begin
        st_next.rresp = `RESP_SLVERR;
      end
    end

    //////////////////////////////////////////////////////////////////
    if (st_reg.go) begin
      unique case (op)
        `OP_IO_SET, `OP_IO_CLR: begin
          // RULE1 RULE2 read phase of bit update
          st_next.mem.re   = 1'b1;
          st_next.mem.io   = 1'b1;
          st_next.mem.addr = {11'h000, r_idx};
          st_next.ph       = PH_MEM;
        end
        `OP_SHIFT_L: begin
          // RULE3 zero into bit 0
          res = {rd_val[6:0], 1'b0};
          cy  = rd_val[7];
          sh  = 1'b1;
        end
        `OP_SHIFT_R: begin
          // RULE4 zero into bit 7
          res = {1'b0, rd_val[7:1]};
          cy  = rd_val[0];
          sh  = 1'b1;
        end
        `OP_ROT_L: begin
          // RULE5 carry in at bit 0
          res = {rd_val[6:0], st_reg.flags[`FLAG_C]};
          cy  = rd_val[7];
          sh  = 1'b1;
        end
        `OP_ROT_R: begin
          // RULE6 carry in at bit 7
          res = {st_reg.flags[`FLAG_C], rd_val[7:1]};
          cy  = rd_val[0];
          sh  = 1'b1;
        end
        `OP_SHIFT_A: begin
          // RULE7 sign bit held
          res = {rd_val[7], rd_val[7:1]};
          cy  = rd_val[0];
          sh  = 1'b1;
        end
        `OP_SWAP: begin
          // RULE8 exchange halves
          st_next.rf[d_idx] = {rd_val[3:0], rd_val[7:4]};
        end
        `OP_FLAG_SET: begin
          // RULE9 RULE10 one flag set
          st_next.flags[bit_idx] = 1'b1;
        end
        `OP_FLAG_CLR: begin
          // RULE9 RULE10 one flag cleared
          st_next.flags[bit_idx] = 1'b0;
        end
        `OP_T_STORE: begin
          // RULE11 bit into T
          st_next.flags[`FLAG_T] = st_reg.rf[r_idx][bit_idx];
        end
        `OP_T_LOAD: begin
          // RULE12 T into bit
          st_next.rf[d_idx][bit_idx] = st_reg.flags[`FLAG_T];
        end
        `OP_COPY: begin
          // RULE16 single copy
          st_next.rf[d_idx] = st_reg.rf[r_idx];
        end
        `OP_COPY_PAIR: begin
          // RULE16 even-aligned pair copy
          st_next.rf[dp]         = st_reg.rf[rp];
          st_next.rf[dp + 5'h01] = st_reg.rf[rp + 5'h01];
        end
        `OP_IMM: begin
          // RULE16 constant load
          st_next.rf[d_idx] = imm;
        end
        `OP_LOAD: begin
          // RULE13 RULE14 address issue, pre-decrement first
          pn = (r_idx[1:0] == `MODE_PRE) ? ptr - 16'h0001 : ptr;
          st_next.rf[p_idx]         = pn[7:0];
          st_next.rf[p_idx + 5'h01] = pn[15:8];
          st_next.mem.re   = 1'b1;
          st_next.mem.io   = 1'b0;
          st_next.mem.addr = pn;
          st_next.ph       = PH_MEM;
        end
        `OP_LOAD_DISP: begin
          // RULE15 pointer left as is
          st_next.mem.re   = 1'b1;
          st_next.mem.io   = 1'b0;
          st_next.mem.addr = ptr + {10'h000, imm[5:0]};
          st_next.ph       = PH_MEM;
        end
        default: begin
        end
      endcase
      if (sh) begin
        // RULE17 shift flag update
        st_next.rf[d_idx]      = res;
        st_next.flags[`FLAG_C] = cy;
        st_next.flags[`FLAG_Z] = (res == 8'h00);
        st_next.flags[`FLAG_N] = res[7];
        st_next.flags[`FLAG_V] = res[7] ^ cy;
      end
    end

    //////////////////////////////////////////////////////////////////
    if (st_reg.ph == PH_MEM) begin
      st_next.ph = PH_IDLE;
      if (op == `OP_IO_SET || op == `OP_IO_CLR) begin
        // RULE1 RULE2 write back, other bits kept
        st_next.mem.we    = 1'b1;
        st_next.mem.wdata = mem_rdata;
        st_next.mem.wdata[bit_idx] = (op == `OP_IO_SET);
      end else begin
        // RULE13 post-increment after the read
        if (op == `OP_LOAD && r_idx[1:0] == `MODE_POST) begin
          pn = ptr + 16'h0001;
          st_next.rf[p_idx]         = pn[7:0];
          st_next.rf[p_idx + 5'h01] = pn[15:8];
        end
        st_next.rf[d_idx] = mem_rdata;
      end
    end

    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready  = !st_next.w_got && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
    st_next.busy    = st_next.go || (st_next.ph == PH_MEM);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg       <= '0;
      st_reg.flags <= `FLAGS_RST;
      st_reg.cmd   <= `CMD_RST;
      st_reg.ph    <= PH_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign awready = st_reg.awready;
  assign wready  = st_reg.wready;
  assign arready = st_reg.arready;
  assign bvalid  = st_reg.bvalid;
  assign bresp   = st_reg.bresp;
  assign rvalid  = st_reg.rvalid;
  assign rdata   = st_reg.rdata;
  assign rresp   = st_reg.rresp;
  assign mem_req = st_reg.mem;
  assign busy    = st_reg.busy;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_io_read;
    st_reg.mem.re && st_reg.mem.io;
  endsequence

  a_io_set_rmw: assert property (st_reg.go && op == `OP_IO_SET |=> seq_io_read ##1 // RULE1
    (st_reg.mem.we && st_reg.mem.wdata == ($past(mem_rdata) | (8'h01 << bit_idx))
     && $stable(st_reg.flags)))
    else $error("io bit set wrong");
  a_io_clr_rmw: assert property (st_reg.go && op == `OP_IO_CLR |=> seq_io_read ##1 // RULE2
    (st_reg.mem.we && st_reg.mem.wdata == ($past(mem_rdata) & ~(8'h01 << bit_idx))))
    else $error("io bit clear wrong");
  a_shl_result: assert property (st_reg.go && op == `OP_SHIFT_L |=> // RULE3
    st_reg.rf[$past(d_idx)] == {$past(rd_val[6:0]), 1'b0} &&
    st_reg.flags[`FLAG_C] == $past(rd_val[7]))
    else $error("left shift wrong");
  a_rotr_carry: assert property (st_reg.go && op == `OP_ROT_R |=> // RULE6
    st_reg.rf[$past(d_idx)][7] == $past(st_reg.flags[`FLAG_C]) &&
    st_reg.flags[`FLAG_C] == $past(rd_val[0]))
    else $error("rotate right wrong");
  a_arith_sign: assert property (st_reg.go && op == `OP_SHIFT_A |=> // RULE7
    st_reg.rf[$past(d_idx)][7:6] == {2{$past(rd_val[7])}})
    else $error("arith shift lost sign");
  a_shift_flags: assert property (st_reg.go && op inside {[`OP_SHIFT_L:`OP_SHIFT_A]} |=> // RULE17
    st_reg.flags[`FLAG_V] == (st_reg.flags[`FLAG_N] ^ st_reg.flags[`FLAG_C]) &&
    st_reg.flags[`FLAG_Z] == (st_reg.rf[$past(d_idx)] == 8'h00))
    else $error("shift flags wrong");
  a_swap_flags: assert property (st_reg.go && op == `OP_SWAP |=> // RULE8
    $stable(st_reg.flags) && st_reg.rf[$past(d_idx)] == {$past(rd_val[3:0]), $past(rd_val[7:4])})
    else $error("swap wrong");
  a_flag_set: assert property (st_reg.go && op == `OP_FLAG_SET |=> // RULE9
    st_reg.flags == ($past(st_reg.flags) | (8'h01 << $past(bit_idx))))
    else $error("flag set wrong");
  a_flag_clear: assert property (st_reg.go && op == `OP_FLAG_CLR |=> // RULE10
    st_reg.flags == ($past(st_reg.flags) & ~(8'h01 << $past(bit_idx))))
    else $error("flag clear wrong");
  a_shr_result: assert property (st_reg.go && op == `OP_SHIFT_R |=> // RULE4
    st_reg.rf[$past(d_idx)] == {1'b0, $past(rd_val[7:1])} &&
    st_reg.flags[`FLAG_C] == $past(rd_val[0]))
    else $error("right shift wrong");
  a_rotl_carry: assert property (st_reg.go && op == `OP_ROT_L |=> // RULE5
    st_reg.rf[$past(d_idx)] == {$past(rd_val[6:0]), $past(st_reg.flags[`FLAG_C])} &&
    st_reg.flags[`FLAG_C] == $past(rd_val[7]))
    else $error("rotate left wrong");
  a_t_store: assert property (st_reg.go && op == `OP_T_STORE |=> // RULE11
    st_reg.flags[`FLAG_T] == $past(st_reg.rf[r_idx][bit_idx]) &&
    (st_reg.flags & 8'hBF) == ($past(st_reg.flags) & 8'hBF))
    else $error("t store wrong");
  a_t_load: assert property (st_reg.go && op == `OP_T_LOAD |=> // RULE12
    st_reg.rf[$past(d_idx)][$past(bit_idx)] == $past(st_reg.flags[`FLAG_T]) &&
    $stable(st_reg.flags))
    else $error("t load wrong");
  a_imm_load: assert property (st_reg.go && op == `OP_IMM |=> // RULE16
    st_reg.rf[$past(d_idx)] == $past(imm) && $stable(st_reg.flags))
    else $error("immediate load wrong");
  a_load_post: assert property (st_reg.go && op == `OP_LOAD && // RULE13
    r_idx[1:0] == `MODE_POST |=>
    st_reg.mem.re && st_reg.mem.addr == $past(ptr) ##1 ptr == $past(ptr, 2) + 16'h0001)
    else $error("post increment wrong");
  a_load_pre: assert property (st_reg.go && op == `OP_LOAD && // RULE14
    r_idx[1:0] == `MODE_PRE |=>
    st_reg.mem.re && st_reg.mem.addr == $past(ptr) - 16'h0001 && ptr == st_reg.mem.addr)
    else $error("pre decrement wrong");
  a_load_disp: assert property (st_reg.go && op == `OP_LOAD_DISP |=> // RULE15
    st_reg.mem.addr == $past(ptr) + {10'h000, $past(imm[5:0])} ##1 $stable(ptr))
    else $error("displaced load moved pointer");

endmodule

/* dv/data_io_model.sv */
`timescale 1ns/1ps
module data_io_model
  import exec_pkg::*;
(
  input  wire logic     aclk,
  input  wire mem_req_s mem_req,
  output logic [7:0]    mem_rdata
);
  // Idle bus shows a moving pattern, so a read outside re cannot pass by luck
  logic [7:0] noise_reg = 8'hA5;

  always_ff @(posedge aclk) noise_reg <= noise_reg + 8'h3B;

  ////////////////////////////////////////////////////////////////////////
  // Fixed content per address; write bytes are judged by the bench instead
  always_comb mem_rdata = !mem_req.re ? noise_reg
                        : mem_req.io ? (mem_req.addr[7:0] ^ 8'hC3)
                        : (mem_req.addr[7:0] + mem_req.addr[15:8] + 8'h29);
endmodule

/* dv/bit_flag_load_exec_unit_tb.sv */
`timescale 1ns/1ps
`include "exec_cfg.svh"
module bit_flag_load_exec_unit_tb
  import exec_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, busy;
  logic [7:0]  awaddr, araddr, mem_rdata;
  logic [31:0] wdata, rdata, rnd_reg;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  mem_req_s    mem_req;
  logic [33:0] rq[$];
  logic [23:0] wq[$];
  logic [1:0]  bq[$];
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;

  bit_flag_load_exec_unit i_bit_flag_load_exec_unit (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .busy(busy)
  );

  data_io_model i_data_io_model (.aclk(aclk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] rnd();
    rnd_reg = rnd_reg ^ (rnd_reg << 13);
    rnd_reg = rnd_reg ^ (rnd_reg >> 17);
    rnd_reg = rnd_reg ^ (rnd_reg << 5);
    return rnd_reg[7:0];
  endfunction

  function automatic logic [7:0] memv(input logic [15:0] a);
    return a[7:0] + a[15:8] + 8'h29;
  endfunction

  // Result byte in [7:0], new flags in [15:8]
  function automatic logic [15:0] shf(input logic [4:0] op, input logic [7:0] v, f);
    logic [7:0] r;
    logic [7:0] n;
    logic       c;
    c = f[0];
    case (op)
      `OP_SHIFT_L: {c, r} = {v, 1'h0};
      `OP_SHIFT_R: {r, c} = {1'h0, v};
      `OP_ROT_L:   {c, r} = {v, f[0]};
      `OP_ROT_R:   {r, c} = {f[0], v};
      `OP_SHIFT_A: {r, c} = {v[7], v};
      default:     r = {v[3:0], v[7:4]};
    endcase
    n = f;
    if (op != `OP_SWAP)
      n[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
    return {n, r};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OKAY);
    bq.push_back(r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) bready <= 1'h0;
    end while (bvalid !== 1'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    rq.push_back({r, e});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) rready <= 1'h0;
    end while (rvalid !== 1'h1);
  endtask

  // Waits on busy so no command write lands while one runs and gets refused
  task automatic cmd(input logic [4:0] op, input logic [4:0] d, s, input logic [7:0] i);
    wr(`OFF_CMD, {i, 3'h0, s, 3'h0, d, 3'h0, op});
    do @(posedge aclk); while (busy !== 1'h0);
  endtask

  task automatic rset(input logic [4:0] i, input logic [7:0] v);
    wr(`OFF_SEL, {27'h0, i});
    wr(`OFF_DATA, {24'h0, v});
  endtask

  task automatic rchk(input logic [4:0] i, input logic [7:0] v);
    wr(`OFF_SEL, {27'h0, i});
    rd(`OFF_DATA, {24'h0, v}, `RESP_OKAY);
  endtask

  task automatic fset(input logic [7:0] f);
    wr(`OFF_FLAGS, {24'h0, f});
  endtask

  task automatic fchk(input logic [7:0] f);
    rd(`OFF_FLAGS, {24'h0, f}, `RESP_OKAY);
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (aresetn && mem_req.we)
      chk("io_write", {10'h0, mem_req.addr, mem_req.wdata}, {10'h0, wq.pop_front()});
    if (aresetn && bvalid && bready)
      chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    if (aresetn && rvalid && rready)
      chk("read", {rresp, rdata}, rq.pop_front());
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    int          k;
    logic [7:0]  v, w, u, f;
    logic [15:0] e, p, a;
    logic [4:0]  lo;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    rnd_reg = 32'h62E4;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    fchk(`FLAGS_RST);
    rd(`OFF_CMD, `CMD_RST, `RESP_OKAY);
    // Last six passes use edge values 01 and 80 for carry and zero
    for (k = 0; k < 18; k++) begin
      v = (k < 12) ? rnd() : (k[0] ? 8'h01 : 8'h80);
      f = rnd();
      e = shf(`OP_SHIFT_L + 5'(k % 6), v, f);
      rset(5'h05, v);
      fset(f);
      cmd(`OP_SHIFT_L + 5'(k % 6), 5'h05, 5'h00, 8'h00);
      rchk(5'h05, e[7:0]);
      fchk(e[15:8]);
    end
    for (k = 0; k < 16; k++) begin
      f = rnd();
      fset(f);
      cmd(k < 8 ? `OP_FLAG_SET : `OP_FLAG_CLR, 5'h00, 5'h00, 8'(k % 8));
      f[k % 8] = (k < 8);
      fchk(f);
    end
    for (k = 0; k < 8; k++) begin
      v = rnd();
      w = rnd();
      f = rnd();
      rset(5'h03, v);
      rset(5'h04, w);
      fset(f);
      cmd(`OP_T_STORE, 5'h00, 5'h03, 8'(k));
      f[6] = v[k];
      fchk(f);
      cmd(`OP_T_LOAD, 5'h04, 5'h00, 8'(7 - k));
      w[7 - k] = f[6];
      rchk(5'h04, w);
    end
    v = rnd();
    w = rnd();
    u = rnd();
    f = rnd();
    rset(5'h01, v);
    rset(5'h0A, w);
    rset(5'h0B, u);
    fset(f);
    cmd(`OP_COPY, 5'h02, 5'h01, 8'h00);
    cmd(`OP_COPY_PAIR, 5'h07, 5'h0B, 8'h00);
    cmd(`OP_IMM, 5'h09, 5'h00, ~u);
    rchk(5'h02, v);
    rchk(5'h06, w);
    rchk(5'h07, u);
    rchk(5'h09, ~u);
    fchk(f);
    for (k = 0; k < 8; k++) begin
      v = rnd();
      p = {11'h0, v[4:0]};
      w = p[7:0] ^ 8'hC3;
      w[k] = ~k[0];
      wq.push_back({p, w});
      cmd(k[0] ? `OP_IO_CLR : `OP_IO_SET, 5'h00, p[4:0], 8'(k));
    end
    fchk(f);
    // Pointer low bytes FF (post-increment) and 00 (pre-decrement) force a carry into or a borrow from the high byte
    for (k = 0; k < 9; k++) begin
      p = {rnd(), rnd()};
      if (k % 3 != 0) p[7:0] = (k % 3 == 1) ? 8'hFF : 8'h00;
      lo = 5'(26 + 2 * (k / 3));
      rset(lo, p[7:0]);
      rset(lo + 5'h01, p[15:8]);
      cmd(`OP_LOAD, 5'h02, 5'(4 * (k / 3) + k % 3), 8'h00);
      a = (k % 3 == 2) ? p - 16'h0001 : p;
      rchk(5'h02, memv(a));
      if (k % 3 == 1) a = p + 16'h0001;
      rchk(lo, a[7:0]);
      rchk(lo + 5'h01, a[15:8]);
    end
    for (k = 1; k < 3; k++) begin
      p = {rnd(), rnd()};
      v = (k == 2) ? 8'h3F : (rnd() & 8'h3F);
      lo = 5'(26 + 2 * k);
      rset(lo, p[7:0]);
      rset(lo + 5'h01, p[15:8]);
      cmd(`OP_LOAD_DISP, 5'h02, 5'(4 * k), v);
      rchk(5'h02, memv(p + {8'h0, v}));
      rchk(lo, p[7:0]);
      rchk(lo + 5'h01, p[15:8]);
    end
    // Unmapped write is refused and must leave the flags alone
    wr(8'h10, 32'hFFFF_FFFF, `RESP_SLVERR);
    fchk(f);
    rd(8'h10, 32'h0, `RESP_SLVERR);
    repeat (4) @(posedge aclk);
    chk("pending", 34'(rq.size() + wq.size() + bq.size()), 34'h0);
    final_report();
  end
endmodule
